// ### opcode_decoder.sv
// Purpose: Fetch and sequence instructions, decode register and jump fields.
// Assumes: Program memory answers in the same cycle as code_addr is held.
// Notes: Branch decisions come from the datapath as take_branch.
`timescale 1ns/1ps
module opcode_decoder
  import opdec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  code_data,
  input  wire logic        take_branch,
  input  wire logic [15:0] jump_base,
  output logic [15:0]      code_addr,
  output logic [15:0]      pc,
  output logic [7:0]       opcode,
  output logic [7:0]       operand1,
  output logic [7:0]       operand2,
  output op_class_t        op_class,
  output logic [1:0]       op_len,
  output logic [2:0]       op_mcycles,
  output logic [2:0]       working_register,
  output logic             pointer_register,
  output logic [10:0]      abs_target,
  output logic             mcycle_tick,
  output logic             exec_done
);
  dec_state_t  state;
  logic [1:0]  phase;
  logic [1:0]  bytes_got;
  logic [2:0]  mc_left;
  op_class_t   t_class;
  logic [1:0]  t_len;
  logic [2:0]  t_mc;
  logic [15:0] rel_target;

  opcode_table u_table (
    .opcode     (code_data),
    .op_class   (t_class),
    .op_len     (t_len),
    .op_mcycles (t_mc)
  );

  // Core clock divided by two into machine cycles.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase       <= 2'h0;
      mcycle_tick <= 1'b0;
    end
    else
    begin
      mcycle_tick <= (phase == CLKS_PER_MCYCLE - 2'h1);
      phase <= (phase == CLKS_PER_MCYCLE - 2'h1) ? 2'h0 : phase + 2'h1;
    end
  end

  // The displacement is added to the PC already past the whole instruction.
  assign rel_target = pc + {{8{operand1[7]}}, operand1};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_FETCH; pc <= PC_RESET; code_addr <= PC_RESET;
      opcode <= OP_NOP; operand1 <= 8'h00; operand2 <= 8'h00;
      op_class <= CL_NOP; op_len <= LEN_ONE; op_mcycles <= MC_ONE;
      working_register <= 3'h0; pointer_register <= 1'b0;
      abs_target <= 11'h000; bytes_got <= 2'h0; mc_left <= 3'h0;
      exec_done <= 1'b0;
    end
    else
    begin
      exec_done <= 1'b0;
      case (state)
        ST_FETCH:
        begin
          opcode <= code_data; op_class <= t_class;
          op_len <= t_len; op_mcycles <= t_mc;
          working_register <= code_data[2:0];
          pointer_register <= code_data[0];
          abs_target <= {code_data[7:5], 8'h00};
          pc <= pc + 16'h0001; code_addr <= pc + 16'h0001;
          bytes_got <= LEN_ONE;
          mc_left <= t_mc;
          state <= (t_len == LEN_ONE) ? ST_EXEC : ST_OPERAND;
        end
        ST_OPERAND:
        begin
          if (bytes_got == LEN_ONE)
          begin
            operand1 <= code_data;
            abs_target <= {abs_target[10:8], code_data};
          end
          else
            operand2 <= code_data;
          pc <= pc + 16'h0001; code_addr <= pc + 16'h0001;
          bytes_got <= bytes_got + 2'h1;
          if (bytes_got + 2'h1 == op_len)
            state <= ST_EXEC;
        end
        ST_EXEC:
        begin
          if (mcycle_tick)
          begin
            if (mc_left <= MC_ONE)
            begin
              exec_done <= 1'b1;
              state <= ST_FETCH;
              if (op_class == CL_ABS)
              begin
                pc <= {pc[15:11], abs_target}; code_addr <= {pc[15:11], abs_target};
              end
              else if (op_class == CL_LONG || op_class == CL_RET || op_class == CL_INDJ)
              begin
                pc <= jump_base; code_addr <= jump_base;
              end
              else if (op_class == CL_REL || (op_class == CL_COND && take_branch))
              begin
                pc <= (op_len == LEN_THREE) ? pc + {{8{operand2[7]}}, operand2} : rel_target;
                code_addr <= (op_len == LEN_THREE) ? pc + {{8{operand2[7]}}, operand2} : rel_target;
              end
            end
            mc_left <= mc_left - 3'h1;
          end
        end
        default: state <= ST_FETCH;
      endcase
    end
  end

  mc_tick_a: assert property (@(posedge clk) disable iff (rst)
    mcycle_tick |=> !mcycle_tick ##1 mcycle_tick) else $error("tick spacing wrong");
  len_fetch_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_FETCH && t_len == LEN_THREE) |=> state == ST_OPERAND ##1 state == ST_OPERAND ##1 state == ST_EXEC) else $error("operand count wrong");
  reg_index_a: assert property (@(posedge clk) disable iff (rst)
    state == ST_FETCH |=> working_register == $past(code_data[2:0])) else $error("register index wrong");
  abs_hi_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_FETCH && t_class == CL_ABS) |=> abs_target[10:8] == $past(code_data[7:5])) else $error("abs bits wrong");
  pc_step_a: assert property (@(posedge clk) disable iff (rst)
    state != ST_EXEC |=> pc == $past(pc) + 16'h0001) else $error("pc not stepped");
  movdd_len_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_FETCH && code_data == OP_MOVDD) |=> op_len == LEN_THREE && op_mcycles == MC_TWO) else $error("move length wrong");
  ret_cyc_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_FETCH && (code_data == OP_RET || code_data == OP_INT_RET)) |=> op_len == LEN_ONE && op_mcycles == MC_TWO) else $error("return timing wrong");
  xch_cyc_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_FETCH && code_data[7:1] == P_XCHDI) |=> op_mcycles == MC_ONE && op_class == CL_SWAP) else $error("exchange timing wrong");
  movcb_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_FETCH && code_data == OP_MOVCB) |=> op_mcycles == MC_ONE && op_len == LEN_TWO) else $error("bit move wrong");
endmodule : opcode_decoder

// ### opcode_decoder_test.sv
// Purpose: Self-checking bench for the opcode decoder.
// Assumes: Branch decisions and jump targets are played by the bench.
// Notes: Each program is laid out so that a wrong target fetches junk.
`timescale 1ns/1ps
module opcode_decoder_test
  import opdec_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [7:0]  code_data;
  logic        take_branch;
  logic [15:0] jump_base;
  logic [15:0] code_addr;
  logic [15:0] pc;
  logic [7:0]  opcode;
  logic [7:0]  operand1;
  logic [7:0]  operand2;
  op_class_t   op_class;
  logic [1:0]  op_len;
  logic [2:0]  op_mcycles;
  logic [2:0]  working_register;
  logic        pointer_register;
  logic [10:0] abs_target;
  logic        mcycle_tick;
  logic        exec_done;
  int          error_cnt;
  int          tests_run;

  opcode_decoder u_dut (.clk(clk), .rst(rst), .code_data(code_data),
    .take_branch(take_branch), .jump_base(jump_base),
    .code_addr(code_addr), .pc(pc), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .op_class(op_class),
    .op_len(op_len), .op_mcycles(op_mcycles),
    .working_register(working_register),
    .pointer_register(pointer_register), .abs_target(abs_target),
    .mcycle_tick(mcycle_tick), .exec_done(exec_done));

  prog_mem_model u_mem (.code_addr(code_addr), .code_data(code_data));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic results();
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // An entry is opcode, length, machine cycles and branch displacement.
  task automatic run_ops(input logic [23:0] ops[$]);
    logic [15:0] cur;
    logic [15:0] tgt[$];
    logic [7:0]  o1[$];
    logic [7:0]  op;
    logic        is_abs;
    int          n;
    rst = 1'b1;
    cur = 16'h0000;
    for (int i = 0; i < 2048; i++)
      u_mem.mem[i] = 8'hA5;
    foreach (ops[k])
    begin
      op = ops[k][23:16];
      is_abs = (op[4:0] == ABS_LOW) || (op[4:0] == CALL_LOW);
      o1.push_back(ops[k][13:12] == 2'h3 ? 8'h5A : ops[k][7:0]);
      tgt.push_back(cur + 16'(ops[k][13:12]) + 16'(ops[k][7:0]));
      if (is_abs)
      begin
        tgt[k] = {cur[15:11], op[7:5], 8'(cur + 16'h0002)};
        o1[k] = tgt[k][7:0];
      end
      u_mem.mem[cur[10:0]] = op;
      u_mem.mem[11'(cur + 16'h0001)] = o1[k];
      u_mem.mem[11'(cur + 16'h0002)] = ops[k][7:0];
      cur = tgt[k];
    end
    step();
    foreach (ops[k])
    begin
      op = ops[k][23:16];
      jump_base = tgt[k];
      take_branch = ops[k][7:0] != 8'h00;
      is_abs = (op[4:0] == ABS_LOW) || (op[4:0] == CALL_LOW);
      rst = 1'b0;
      n = 0;
      // The fetch edge is counted as well, so every entry is timed alike.
      do
      begin
        step();
        n++;
        if (n > 40)
        begin
          error_cnt++;
          $display("unexpected at %0t: no completion", $time);
          results();
        end
      end
      while (exec_done !== 1'b1);
      check(opcode === op, "opcode fetched from wrong place");
      check(op_len === ops[k][13:12], "instruction length");
      check(op_mcycles === ops[k][10:8], "machine cycle count");
      check(n >= 2 * ops[k][10:8], "finished too early");
      check(n <= 2 * ops[k][10:8] + 8, "finished too late");
      check(working_register === op[2:0], "register index");
      check(pointer_register === op[0], "pointer register index");
      if (ops[k][13:12] != 2'h1)
        check(operand1 === o1[k], "first operand");
      if (ops[k][13:12] == 2'h3)
        check(operand2 === ops[k][7:0], "second operand");
      if (is_abs)
      begin
        check(abs_target === tgt[k][10:0], "absolute target");
        check(op_class === CL_ABS, "absolute class");
      end
      if (op == OP_RET || op == OP_INT_RET)
        check(op_class === CL_RET, "return class");
      if (op == OP_JMPAD)
        check(op_class === CL_INDJ, "indirect jump class");
      check(pc === tgt[k] && code_addr === tgt[k], "next fetch");
    end
  endtask : run_ops

  task automatic reset_check();
    rst = 1'b1;
    step();
    step();
    check(pc === PC_RESET && code_addr === PC_RESET, "reset address");
    check(op_len === LEN_ONE && op_mcycles === MC_ONE, "reset decode");
    check(op_class === CL_NOP, "reset class");
    check(exec_done === 1'b0, "done during reset");
  endtask : reset_check

  task automatic tick_check();
    int highs;
    logic last;
    highs = 0;
    rst = 1'b0;
    step();
    last = mcycle_tick;
    for (int i = 0; i < 8; i++)
    begin
      step();
      highs += int'(mcycle_tick === 1'b1);
      check(mcycle_tick !== last, "tick not every second clock");
      last = mcycle_tick;
    end
    check(highs == 4, "tick count over eight clocks");
  endtask : tick_check

  task automatic moves();
    run_ops('{24'hA82200, 24'hAF2200, 24'hA51100});
    run_ops('{24'h853200, 24'h000000 | 24'h001100});
    run_ops('{24'hA62200, 24'hA72200});
    run_ops('{24'h903200});
    run_ops('{24'h931200, 24'h831200});
    run_ops('{24'hE01200, 24'hE21200, 24'hE31200});
    run_ops('{24'hF01200, 24'hF21200, 24'hF31200});
    run_ops('{24'hC02200, 24'hD02200});
    run_ops('{24'hD61100, 24'hD71100, 24'hC81100, 24'hCF1100});
  endtask : moves

  task automatic booleans();
    run_ops('{24'hA22100, 24'h922200});
    run_ops('{24'h822200, 24'hA02200});
  endtask : booleans

  task automatic branches();
    run_ops('{24'h123200, 24'h221200, 24'h321200});
    run_ops('{24'h023200, 24'h802204});
    run_ops('{24'h203203, 24'h303200, 24'h103201});
    run_ops('{24'h731200, 24'h602203, 24'h702200});
    run_ops('{24'hB53202, 24'hB43200, 24'hB83200, 24'hBF3201});
    run_ops('{24'hB63200, 24'hB73200});
    run_ops('{24'hD82201, 24'hDF2200, 24'hD53202});
    run_ops('{24'h112200, 24'hE12200, 24'h001100});
  endtask : branches

  initial
  begin
    rst = 1'b1;
    take_branch = 1'b0;
    jump_base = 16'h0000;
    error_cnt = 0;
    tests_run = 0;
    repeat (3) step();
    reset_check();
    tick_check();
    moves();
    booleans();
    branches();
    results();
  end
endmodule : opcode_decoder_test

// ### opcode_table.sv
// Purpose: Combinational opcode table giving class, length and cycles.
// Assumes: Opcodes outside the covered groups fall back to one byte.
// Notes: Arithmetic and logical groups are decoded elsewhere.
`timescale 1ns/1ps
module opcode_table
  import opdec_pkg::*;
(
  input  wire logic [7:0] opcode,
  output op_class_t       op_class,
  output logic [1:0]      op_len,
  output logic [2:0]      op_mcycles
);
  always_comb
  begin
    op_class   = CL_OTHER;
    op_len     = LEN_ONE;
    op_mcycles = MC_ONE;
    if (opcode[4:0] == ABS_LOW || opcode[4:0] == CALL_LOW)
    begin
      op_class = CL_ABS; op_len = LEN_TWO; op_mcycles = MC_TWO;
    end
    else
    case (opcode[7:3])
      G_MOVRD: begin op_class = CL_MOVE; op_len = LEN_TWO; op_mcycles = MC_TWO; end
      G_MOVDR: begin op_class = CL_MOVE; op_len = LEN_TWO; op_mcycles = MC_TWO; end
      G_MOVAR, G_MOVRA: begin op_class = CL_MOVE; end
      G_MOVRI: begin op_class = CL_MOVE; op_len = LEN_TWO; end
      G_CJR:   begin op_class = CL_COND; op_len = LEN_THREE; op_mcycles = MC_TWO; end
      G_DJR:   begin op_class = CL_COND; op_len = LEN_TWO; op_mcycles = MC_TWO; end
      G_XCHR:  begin op_class = CL_SWAP; end
      default:
      case (opcode[7:1])
        P_MOVID: begin op_class = CL_MOVE; op_len = LEN_TWO; op_mcycles = MC_TWO; end
        P_MOVDP: begin op_class = CL_MOVE; op_len = LEN_TWO; op_mcycles = MC_TWO; end
        P_MOVAP, P_MOVPA: begin op_class = CL_MOVE; end
        P_MOVPI: begin op_class = CL_MOVE; op_len = LEN_TWO; end
        P_XRRI, P_XWRI: begin op_class = CL_EXT; op_mcycles = MC_TWO; end
        P_XCHDI, P_XCHP: begin op_class = CL_SWAP; end
        P_CJI:   begin op_class = CL_COND; op_len = LEN_THREE; op_mcycles = MC_TWO; end
        default:
        case (opcode)
          OP_NOP:   begin op_class = CL_NOP; end
          OP_MOVAD, OP_MOVDA, OP_MOVAI: begin op_class = CL_MOVE; op_len = LEN_TWO; end
          OP_MOVDD, OP_MOVDI: begin op_class = CL_MOVE; op_len = LEN_THREE; op_mcycles = MC_TWO; end
          OP_DPLD:  begin op_class = CL_MOVE; op_len = LEN_THREE; op_mcycles = MC_TWO; end
          OP_CDP, OP_CPC: begin op_class = CL_CODE; op_mcycles = MC_TWO; end
          OP_XRDP, OP_XWDP: begin op_class = CL_EXT; op_mcycles = MC_TWO; end
          OP_PUSH, OP_POP: begin op_class = CL_STACK; op_len = LEN_TWO; op_mcycles = MC_TWO; end
          OP_SWAP_DIR: begin op_class = CL_SWAP; op_len = LEN_TWO; end
          OP_CLRC, OP_SETC, OP_CPLC: begin op_class = CL_BOOL; end
          OP_CLRB, OP_SETB, OP_CPLB, OP_MOVCB: begin op_class = CL_BOOL; op_len = LEN_TWO; end
          OP_MOVBC, OP_ANLC, OP_ORLNB, OP_ANLNB, OP_ORLNC: begin op_class = CL_BOOL; op_len = LEN_TWO; op_mcycles = MC_TWO; end
          OP_LONG_CALL, OP_LONG_JUMP: begin op_class = CL_LONG; op_len = LEN_THREE; op_mcycles = MC_TWO; end
          OP_RET, OP_INT_RET: begin op_class = CL_RET; op_mcycles = MC_TWO; end
          OP_SHORT_JUMP: begin op_class = CL_REL; op_len = LEN_TWO; op_mcycles = MC_TWO; end
          OP_JB, OP_JNB, OP_BIT_BR_CLR, OP_CJAI, OP_CJAD, OP_DJD: begin op_class = CL_COND; op_len = LEN_THREE; op_mcycles = MC_TWO; end
          OP_JZ, OP_JNZ, OP_JC, OP_JNC: begin op_class = CL_COND; op_len = LEN_TWO; op_mcycles = MC_TWO; end
          OP_JMPAD: begin op_class = CL_INDJ; op_mcycles = MC_TWO; end
          default:  begin op_class = CL_OTHER; end
        endcase
      endcase
    endcase
  end
endmodule : opcode_table

// ### opdec_pkg.sv
// Purpose: Constants and types for the byte-CPU opcode decoder.
// Assumes: 8-bit opcodes, core clock at 40 MHz, no software registers.
// Notes: Opcode values and timing figures are named once here.
package opdec_pkg;
  localparam int          CLK_HZ          = 40000000;
  localparam logic [1:0]  CLKS_PER_MCYCLE = 2'h2;
  localparam logic [1:0]  LEN_ONE         = 2'h1;
  localparam logic [1:0]  LEN_TWO         = 2'h2;
  localparam logic [1:0]  LEN_THREE       = 2'h3;
  localparam logic [2:0]  MC_ONE          = 3'h1;
  localparam logic [2:0]  MC_TWO          = 3'h2;
  localparam logic [2:0]  MC_FOUR         = 3'h4;
  localparam logic [4:0]  ABS_LOW         = 5'h01;
  localparam logic [4:0]  CALL_LOW        = 5'h11;
  localparam logic [15:0] PC_RESET        = 16'h0000;

  localparam logic [7:0] OP_NOP   = 8'h00;
  localparam logic [7:0] OP_LONG_JUMP  = 8'h02;
  localparam logic [7:0] OP_BIT_BR_CLR = 8'h10;
  localparam logic [7:0] OP_LONG_CALL  = 8'h12;
  localparam logic [7:0] OP_JB    = 8'h20;
  localparam logic [7:0] OP_RET   = 8'h22;
  localparam logic [7:0] OP_JNB   = 8'h30;
  localparam logic [7:0] OP_INT_RET    = 8'h32;
  localparam logic [7:0] OP_JC    = 8'h40;
  localparam logic [7:0] OP_JNC   = 8'h50;
  localparam logic [7:0] OP_JZ    = 8'h60;
  localparam logic [7:0] OP_JNZ   = 8'h70;
  localparam logic [7:0] OP_ORLNC = 8'h72;
  localparam logic [7:0] OP_JMPAD = 8'h73;
  localparam logic [7:0] OP_MOVAI = 8'h74;
  localparam logic [7:0] OP_MOVDI = 8'h75;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_ANLC  = 8'h82;
  localparam logic [7:0] OP_CPC   = 8'h83;
  localparam logic [7:0] OP_MOVDD = 8'h85;
  localparam logic [7:0] OP_DPLD  = 8'h90;
  localparam logic [7:0] OP_MOVBC = 8'h92;
  localparam logic [7:0] OP_CDP   = 8'h93;
  localparam logic [7:0] OP_ORLNB = 8'hA0;
  localparam logic [7:0] OP_MOVCB = 8'hA2;
  localparam logic [7:0] OP_ANLNB = 8'hB0;
  localparam logic [7:0] OP_CPLB  = 8'hB2;
  localparam logic [7:0] OP_CPLC  = 8'hB3;
  localparam logic [7:0] OP_CJAI  = 8'hB4;
  localparam logic [7:0] OP_CJAD  = 8'hB5;
  localparam logic [7:0] OP_PUSH  = 8'hC0;
  localparam logic [7:0] OP_CLRB  = 8'hC2;
  localparam logic [7:0] OP_CLRC  = 8'hC3;
  localparam logic [7:0] OP_SWAP_DIR   = 8'hC5;
  localparam logic [7:0] OP_POP   = 8'hD0;
  localparam logic [7:0] OP_SETB  = 8'hD2;
  localparam logic [7:0] OP_SETC  = 8'hD3;
  localparam logic [7:0] OP_DJD   = 8'hD5;
  localparam logic [7:0] OP_XRDP  = 8'hE0;
  localparam logic [7:0] OP_MOVAD = 8'hE5;
  localparam logic [7:0] OP_XWDP  = 8'hF0;
  localparam logic [7:0] OP_MOVDA = 8'hF5;

  // Upper five bits of the eight-wide register groups.
  localparam logic [4:0] G_MOVRD  = 5'h15;
  localparam logic [4:0] G_MOVAR  = 5'h1D;
  localparam logic [4:0] G_MOVRA  = 5'h1F;
  localparam logic [4:0] G_MOVRI  = 5'h0F;
  localparam logic [4:0] G_MOVDR  = 5'h11;
  localparam logic [4:0] G_CJR    = 5'h17;
  localparam logic [4:0] G_DJR    = 5'h1B;
  localparam logic [4:0] G_XCHR   = 5'h19;
  // Upper seven bits of the pointer-register pairs.
  localparam logic [6:0] P_MOVID  = 7'h53;
  localparam logic [6:0] P_XRRI   = 7'h71;
  localparam logic [6:0] P_XWRI   = 7'h79;
  localparam logic [6:0] P_XCHDI  = 7'h6B;
  localparam logic [6:0] P_CJI    = 7'h5B;
  localparam logic [6:0] P_MOVAP  = 7'h73;
  localparam logic [6:0] P_MOVPA  = 7'h7B;
  localparam logic [6:0] P_MOVPI  = 7'h3B;
  localparam logic [6:0] P_MOVDP  = 7'h43;
  localparam logic [6:0] P_XCHP   = 7'h63;

  typedef enum logic [3:0] {
    CL_OTHER  = 4'h0,
    CL_MOVE   = 4'h1,
    CL_EXT    = 4'h2,
    CL_CODE   = 4'h3,
    CL_STACK  = 4'h4,
    CL_SWAP   = 4'h5,
    CL_BOOL   = 4'h6,
    CL_ABS    = 4'h7,
    CL_LONG   = 4'h8,
    CL_RET    = 4'h9,
    CL_REL    = 4'hA,
    CL_COND   = 4'hB,
    CL_INDJ   = 4'hC,
    CL_NOP    = 4'hD
  } op_class_t;

  typedef enum logic [1:0] {
    ST_FETCH   = 2'h0,
    ST_OPERAND = 2'h1,
    ST_EXEC    = 2'h2
  } dec_state_t;
endpackage : opdec_pkg

// ### prog_mem_model.sv
// Purpose: Program memory that answers the opcode decoder's fetches.
// Assumes: A byte is valid in the same cycle as its address is held.
// Notes: Unwritten bytes hold a reserved opcode, so a stray fetch shows.
`timescale 1ns/1ps
module prog_mem_model
(
  input  wire logic [15:0] code_addr,
  output logic [7:0]       code_data
);
  logic [7:0] mem [0:2047];

  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = 8'hA5;
  end

  assign code_data = mem[code_addr[10:0]];
endmodule : prog_mem_model
